// File: src/fic_fault_interrupt_capture.sv
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module fic_fault_interrupt_capture (
  input wire logic mclk,
  input wire logic rst,
  // register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // asynchronous pins
  input wire logic system_fault_in,
  input wire logic bus_timeout_error_n,
  input wire logic memory_parity_error_in,
  input wire logic memory_protect_fault_in,
  input wire logic user_irq_n_0,
  input wire logic user_irq_n_1,
  input wire logic user_irq_n_2,
  input wire logic user_irq_n_3,
  input wire logic user_irq_n_4,
  input wire logic user_irq_n_5,
  input wire logic user_irq_n_6,
  input wire logic power_fail_n,
  input wire logic master_reset_n,
  input wire logic test_mode_n,
  // processor bus state, same clock domain
  input wire logic ioBusCycle,
  input wire logic memBusCycle,
  input wire logic cpuOwnsBus,
  // discrete outputs and requests
  output logic [7:0] output_discrete_bus,
  output logic outputDiscreteOe,
  output logic userIrqRequest,
  output logic powerFailInterrupt,
  output logic faultRequest
);

  logic [13:0] rawIn;
  logic [13:0] syncIn;
  logic sysFaultS;
  logic busErrS;
  logic parityS;
  logic mprotS;
  logic [6:0] userIrqS_n;
  logic powerFailS;
  logic masterResetS;
  logic [15:0] faultSet;
  logic [15:0] faultHold;
  logic [15:0] pendSet;
  logic [15:0] wrMask;
  logic [15:0] wrData;
  logic [15:0] readVal;
  logic wrFault;
  logic wrPending;
  logic wrMaskReg;
  logic wrStatusOut;
  logic accept;
  fic_pkg::fic_state_t s_q;
  fic_pkg::fic_state_t s_d;

  always_comb begin
    rawIn = fic_pkg::IN_RESET;
    rawIn[fic_pkg::IN_SYS_FAULT] = system_fault_in;
    rawIn[fic_pkg::IN_BUS_ERR_N] = bus_timeout_error_n;
    rawIn[fic_pkg::IN_PARITY] = memory_parity_error_in;
    rawIn[fic_pkg::IN_MEMORY_PROTECT_FAULT_IN] = memory_protect_fault_in;
    rawIn[fic_pkg::IN_USER_LSB +: fic_pkg::USER_IRQ_COUNT] = {
      user_irq_n_6, user_irq_n_5, user_irq_n_4, user_irq_n_3,
      user_irq_n_2, user_irq_n_1, user_irq_n_0};
    rawIn[fic_pkg::IN_POWER_FAIL_N] = power_fail_n;
    rawIn[fic_pkg::IN_TEST_N] = test_mode_n;
    rawIn[fic_pkg::IN_MRESET_N] = master_reset_n;
  end

  // all pins resynchronised before any edge or level use
  fic_sync #(
    .W(fic_pkg::IN_WIDTH),
    .RESET_VAL(fic_pkg::IN_RESET)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .asyncIn(rawIn),
    .syncOut(syncIn)
  );

  assign sysFaultS = syncIn[fic_pkg::IN_SYS_FAULT];
  assign busErrS = ~syncIn[fic_pkg::IN_BUS_ERR_N];
  assign parityS = syncIn[fic_pkg::IN_PARITY];
  assign mprotS = syncIn[fic_pkg::IN_MEMORY_PROTECT_FAULT_IN];
  assign userIrqS_n = syncIn[fic_pkg::IN_USER_LSB +: fic_pkg::USER_IRQ_COUNT];
  assign powerFailS = ~syncIn[fic_pkg::IN_POWER_FAIL_N];
  assign masterResetS = ~syncIn[fic_pkg::IN_MRESET_N];

  // a write or read is taken in the cycle waitrequest is low
  assign accept = (avs_read | avs_write) & (s_q.bus == fic_pkg::FIC_BUS_DONE);
  assign wrMask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wrData = avs_writedata[15:0] & wrMask;
  assign wrFault = accept & avs_write & (avs_address == fic_pkg::ADDR_FAULT);
  assign wrPending = accept & avs_write &
                     (avs_address == fic_pkg::ADDR_PENDING);
  assign wrMaskReg = accept & avs_write & (avs_address == fic_pkg::ADDR_MASK);
  // a write to this address is the output register instruction
  assign wrStatusOut = accept & avs_write &
                       (avs_address == fic_pkg::ADDR_STATUS_OUT);

  always_comb begin
    case (avs_address)
      fic_pkg::ADDR_FAULT: readVal = s_q.fault;
      fic_pkg::ADDR_PENDING: readVal = s_q.pending;
      fic_pkg::ADDR_MASK: readVal = s_q.mask;
      fic_pkg::ADDR_STATUS_OUT: readVal = s_q.statusOut;
      fic_pkg::ADDR_INPUT_STATE: readVal = {2'b00, syncIn};
      default: readVal = 16'h0000;
    endcase
  end

  always_comb begin
    faultSet = 16'h0000;
    faultHold = 16'h0000;
    faultSet[fic_pkg::FAULT_SYS_BIT] = sysFaultS & ~s_q.sysFaultPrev;
    faultHold[fic_pkg::FAULT_SYS_BIT] = sysFaultS;
    if (busErrS) begin
      if (ioBusCycle) begin
        faultSet[fic_pkg::FAULT_IO_BUS_BIT] = 1'b1;
      end else if (memBusCycle) begin
        faultSet[fic_pkg::FAULT_MEM_BUS_BIT] = 1'b1;
      end
    end
    faultHold[fic_pkg::FAULT_IO_BUS_BIT] = busErrS;
    faultHold[fic_pkg::FAULT_MEM_BUS_BIT] = busErrS;
    faultSet[fic_pkg::FAULT_PARITY_BIT] = parityS;
    faultHold[fic_pkg::FAULT_PARITY_BIT] = parityS;
    if (mprotS) begin
      if (cpuOwnsBus) begin
        faultSet[fic_pkg::FAULT_CPU_BIT] = 1'b1;
      end else begin
        faultSet[fic_pkg::FAULT_DMA_BIT] = 1'b1;
      end
    end
    faultHold[fic_pkg::FAULT_CPU_BIT] = mprotS;
    faultHold[fic_pkg::FAULT_DMA_BIT] = mprotS;

    pendSet = 16'h0000;
    // falling edge of each synchronised user line
    pendSet[fic_pkg::PEND_USER_LSB +: fic_pkg::USER_IRQ_COUNT] =
      s_q.userIrqPrev & ~userIrqS_n;
    pendSet[fic_pkg::PEND_POWER_FAIL_BIT] = powerFailS;
  end

  always_comb begin
    s_d = s_q;
    s_d.sysFaultPrev = sysFaultS;
    s_d.userIrqPrev = userIrqS_n;

    case (s_q.bus)
      fic_pkg::FIC_BUS_IDLE: begin
        if (avs_read | avs_write) begin
          s_d.bus = fic_pkg::FIC_BUS_DONE;
          s_d.readData = {16'h0000, readVal};
        end
      end
      fic_pkg::FIC_BUS_DONE: begin
        s_d.bus = fic_pkg::FIC_BUS_IDLE;
      end
      default: begin
        s_d.bus = fic_pkg::FIC_BUS_IDLE;
      end
    endcase

    // write-one-to-clear; a bit whose input still holds cannot be cleared,
    // and a set in the clearing cycle wins
    if (wrFault) begin
      s_d.fault = s_q.fault & ~(wrData & ~faultHold);
    end
    s_d.fault = s_d.fault | faultSet;

    if (wrPending) begin
      s_d.pending = s_q.pending & ~wrData;
    end
    s_d.pending = s_d.pending | pendSet;

    if (wrMaskReg) begin
      s_d.mask = (s_q.mask & ~wrMask) | wrData;
    end
    if (wrStatusOut) begin
      s_d.statusOut = (s_q.statusOut & ~wrMask) | wrData;
    end

    s_d.userIrqReq =
      |(s_d.pending[fic_pkg::PEND_USER_LSB +: fic_pkg::USER_IRQ_COUNT] &
        ~s_d.mask[fic_pkg::PEND_USER_LSB +: fic_pkg::USER_IRQ_COUNT]);
    // mask bit 15 is never consulted
    s_d.powerFailReq = s_d.pending[fic_pkg::PEND_POWER_FAIL_BIT];
    s_d.faultReq = |s_d.fault;
  end

  // master reset pin acts as a synchronous reset once synchronised;
  // it also clears every pending user interrupt
  always_ff @(posedge mclk) begin
    if (rst || masterResetS) begin
      s_q <= fic_pkg::FIC_STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) &
                           (s_q.bus != fic_pkg::FIC_BUS_DONE);
  assign avs_readdata = s_q.readData;
  assign output_discrete_bus =
    s_q.statusOut[fic_pkg::OD_LSB +: fic_pkg::OD_WIDTH];
  // test mode low releases the pins; enable high means driven
  assign outputDiscreteOe = syncIn[fic_pkg::IN_TEST_N];
  assign userIrqRequest = s_q.userIrqReq;
  assign powerFailInterrupt = s_q.powerFailReq;
  assign faultRequest = s_q.faultReq;

endmodule // fic_fault_interrupt_capture
`default_nettype wire

// File: src/fic_pkg.sv
// Behaviour
// - output discrete pins always show status/output register bits 0 to 7
// - status/output register loads only on the output register instruction
// - while the test input is low the output discrete pins are undriven
// - a rising edge on the system fault input sets fault bit 8
// - software cannot clear an input-held fault bit until that input negates
// - bus timeout error during an I/O bus cycle sets fault bit 10
// - while memory parity error is asserted fault bit 13 is set
// - memory-protect fault while processor owns the bus sets fault bit 15
// - memory-protect fault while processor does not own the bus sets bit 14
// - each of seven user interrupts sets its pending bit on a falling pulse
// - master reset clears all pending user interrupts
// - asserting power fail sets pending bit 15 and requests an interrupt
// - power fail interrupt is never masked by the mask register
// - active-low master reset returns the block to its reset state
package fic_pkg;

  localparam int unsigned REG_W = 16;
  localparam int unsigned BUS_W = 32;
  localparam int unsigned ADDR_W = 4;

  // word addresses on the register bus
  localparam logic [3:0] ADDR_FAULT = 4'h0;
  localparam logic [3:0] ADDR_PENDING = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  localparam logic [3:0] ADDR_STATUS_OUT = 4'h3;
  localparam logic [3:0] ADDR_INPUT_STATE = 4'h4;

  // fault register fields
  localparam int unsigned FAULT_MEM_BUS_BIT = 7;
  localparam int unsigned FAULT_SYS_BIT = 8;
  localparam int unsigned FAULT_IO_BUS_BIT = 10;
  localparam int unsigned FAULT_PARITY_BIT = 13;
  localparam int unsigned FAULT_DMA_BIT = 14;
  localparam int unsigned FAULT_CPU_BIT = 15;

  // pending / mask register fields
  localparam int unsigned PEND_USER_LSB = 0;
  localparam int unsigned USER_IRQ_COUNT = 7;
  localparam int unsigned PEND_POWER_FAIL_BIT = 15;

  // output discrete field of the status/output register
  localparam int unsigned OD_LSB = 0;
  localparam int unsigned OD_WIDTH = 8;

  // synchronised input vector, also readable as the input state register
  localparam int unsigned IN_SYS_FAULT = 0;
  localparam int unsigned IN_BUS_ERR_N = 1;
  localparam int unsigned IN_PARITY = 2;
  localparam int unsigned IN_MEMORY_PROTECT_FAULT_IN = 3;
  localparam int unsigned IN_USER_LSB = 4;
  localparam int unsigned IN_POWER_FAIL_N = 11;
  localparam int unsigned IN_TEST_N = 12;
  localparam int unsigned IN_MRESET_N = 13;
  localparam int unsigned IN_WIDTH = 14;
  localparam logic [13:0] IN_RESET = 14'h3ff2;

  localparam logic [15:0] FAULT_RESET = 16'h0000;
  localparam logic [15:0] PENDING_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [15:0] STATUS_OUT_RESET = 16'h0000;
  localparam logic [6:0] USER_IDLE = 7'h7f;

  typedef enum logic {FIC_BUS_IDLE, FIC_BUS_DONE} fic_bus_t;

  typedef struct packed {
    fic_bus_t bus;
    logic [31:0] readData;
    logic [15:0] fault;
    logic [15:0] pending;
    logic [15:0] mask;
    logic [15:0] statusOut;
    logic sysFaultPrev;
    logic [6:0] userIrqPrev;
    logic userIrqReq;
    logic powerFailReq;
    logic faultReq;
  } fic_state_t;

  localparam fic_state_t FIC_STATE_RESET = '{
    bus: FIC_BUS_IDLE,
    readData: 32'h00000000,
    fault: FAULT_RESET,
    pending: PENDING_RESET,
    mask: MASK_RESET,
    statusOut: STATUS_OUT_RESET,
    sysFaultPrev: 1'b0,
    userIrqPrev: USER_IDLE,
    userIrqReq: 1'b0,
    powerFailReq: 1'b0,
    faultReq: 1'b0
  };

endpackage

// File: src/fic_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fic_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } fic_sync_state_t;

  fic_sync_state_t s_q;
  fic_sync_state_t s_d;

  // stage1 feeds only stage2; nothing else may look at it
  always_comb begin
    s_d.stage1 = asyncIn;
    s_d.stage2 = s_q.stage1;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '{stage1: RESET_VAL, stage2: RESET_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign syncOut = s_q.stage2;

endmodule // fic_sync
`default_nettype wire

// File: verification/fic_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
module fic_ext_model (
  input wire logic mclk,
  input wire logic fire,
  input wire logic [2:0] sel,
  output logic system_fault_in,
  output logic bus_timeout_error_n,
  output logic memory_parity_error_in,
  output logic memory_protect_fault_in,
  output logic power_fail_n
);
  logic [4:0] cntQ = 5'h00;
  logic [2:0] selQ = 3'h0;
  logic act;
  // every fault is a 16 clock transient, never left active
  always @(posedge mclk) begin
    if (fire) begin
      cntQ <= 5'h10;
      selQ <= sel;
    end else if (act) begin
      cntQ <= cntQ - 5'h01;
    end
  end
  assign act = cntQ != 5'h00;
  assign system_fault_in = act && selQ == 3'h0;
  assign bus_timeout_error_n = !(act && selQ == 3'h1);
  assign memory_parity_error_in = act && selQ == 3'h2;
  assign memory_protect_fault_in = act && selQ == 3'h3;
  assign power_fail_n = !(act && selQ == 3'h4);
endmodule // fic_ext_model
`default_nettype wire

// File: verification/fic_fault_interrupt_capture_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fic_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic system_fault_in,
  input wire logic bus_timeout_error_n,
  input wire logic memory_parity_error_in,
  input wire logic power_fail_n,
  input wire logic master_reset_n,
  input wire logic test_mode_n,
  input wire logic ioBusCycle,
  input wire logic [7:0] output_discrete_bus,
  input wire logic outputDiscreteOe,
  input wire logic userIrqRequest,
  input wire logic powerFailInterrupt,
  input wire logic faultRequest
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic odWr;
  logic [7:0] wrByte;
  assign odWr = avs_write && !avs_waitrequest &&
                avs_address == fic_pkg::ADDR_STATUS_OUT;
  assign wrByte = avs_writedata[7:0];
  sequence s_sys_rise;
    $rose(system_fault_in) ##1 system_fault_in [*3];
  endsequence
  sequence s_master_reset_n_held;
    !master_reset_n [*5];
  endsequence
  // master reset may clear the bus without any write
  a_od_only_otr: assert property (disable iff (rst || !master_reset_n)
    !$stable(output_discrete_bus) |-> $past(odWr))
    else $error("discrete bus moved without a write");
  a_od_load: assert property (odWr |=>
    output_discrete_bus == $past(wrByte))
    else $error("discrete bus differs from written byte");
  a_oe_test: assert property (!test_mode_n [*5] |->
    !outputDiscreteOe)
    else $error("discrete bus driven in test mode");
  a_sys_edge: assert property (s_sys_rise |-> faultRequest)
    else $error("system fault edge not captured");
  a_sync_lag: assert property ($rose(system_fault_in) && !faultRequest
    |=> !faultRequest [*2])
    else $error("fault seen before two sync stages");
  a_parity_held: assert property (memory_parity_error_in [*4] |->
    faultRequest)
    else $error("parity fault not held");
  a_bus_timeout_error_n_io: assert property (
    (!bus_timeout_error_n && ioBusCycle) [*4] |-> faultRequest)
    else $error("bus timeout not captured");
  a_power_fail_n_held: assert property (!power_fail_n [*5] |->
    powerFailInterrupt)
    else $error("power fail not requested");
  a_master_reset_n_clear: assert property (s_master_reset_n_held |->
    !userIrqRequest && !powerFailInterrupt && output_discrete_bus == 8'h00)
    else $error("master reset left state");
endmodule // fic_checker
bind fic_fault_interrupt_capture fic_checker u_fic_checker (.mclk, .rst,
  .avs_address, .avs_write, .avs_writedata, .avs_waitrequest,
  .system_fault_in, .bus_timeout_error_n, .memory_parity_error_in,
  .power_fail_n, .master_reset_n, .test_mode_n, .ioBusCycle,
  .output_discrete_bus, .outputDiscreteOe, .userIrqRequest,
  .powerFailInterrupt, .faultRequest);
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, fire = 1'b0, master_reset_n = 1'b1;
  logic test_mode_n = 1'b1, ioBusCycle = 1'b0, memBusCycle = 1'b0;
  logic cpuOwnsBus = 1'b0, system_fault_in, bus_timeout_error_n;
  logic memory_parity_error_in, memory_protect_fault_in, power_fail_n;
  logic outputDiscreteOe, userIrqRequest, powerFailInterrupt, faultRequest;
  logic [7:0] output_discrete_bus;
  logic [6:0] irqN = 7'h7f;
  logic [2:0] sel = 3'h0;
  logic [3:0] be = 4'h3;
  logic [16:0] lfsrQ = 17'h16100;
  logic [31:0] expq[$];
  logic [2:0] fSel[6] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h3, 3'h3};
  int fBit[6] = '{8, 10, 7, 13, 15, 14};
  int n_errors = 0, cmp_count = 0, cyc = 0;
  always #25 mclk = ~mclk;
  fic_ext_model u_fic_ext_model (.mclk, .fire, .sel, .system_fault_in,
    .bus_timeout_error_n, .memory_parity_error_in,
    .memory_protect_fault_in, .power_fail_n);
  fic_fault_interrupt_capture u_fic_fault_interrupt_capture (.mclk, .rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(be), .avs_readdata, .avs_waitrequest,
    .system_fault_in, .bus_timeout_error_n, .memory_parity_error_in,
    .memory_protect_fault_in, .user_irq_n_0(irqN[0]),
    .user_irq_n_1(irqN[1]), .user_irq_n_2(irqN[2]),
    .user_irq_n_3(irqN[3]), .user_irq_n_4(irqN[4]),
    .user_irq_n_5(irqN[5]), .user_irq_n_6(irqN[6]), .power_fail_n,
    .master_reset_n, .test_mode_n, .ioBusCycle, .memBusCycle, .cpuOwnsBus,
    .output_discrete_bus, .outputDiscreteOe, .userIrqRequest,
    .powerFailInterrupt, .faultRequest);
  task automatic stop_test();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // for a read, d is the value expected back
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    if (!wr) expq.push_back(d);
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic pulse(input logic [2:0] s);
    fire <= 1'b1;
    sel <= s;
    @(posedge mclk);
    fire <= 1'b0;
  endtask
  function automatic logic [16:0] nxt(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  always @(posedge mclk) begin
    cyc++;
    if (avs_read && avs_waitrequest === 1'b0) begin
      chk(avs_readdata, expq.pop_front());
    end
    if (cyc == 3000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int a = 0; a < 4; a++) bus(1'b0, 4'(a), 32'h0);
    bus(1'b0, 4'h4, 32'h3ff2);
    bus(1'b1, 4'h9, 32'hffff);
    bus(1'b0, 4'h9, 32'h0);
    chk({31'h0, outputDiscreteOe}, 32'h1);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      lfsrQ = nxt(lfsrQ);
      bus(1'b1, 4'h3, {16'h0, lfsrQ[15:0]});
      chk({24'h0, output_discrete_bus}, {24'h0, lfsrQ[7:0]});
      bus(1'b1, 4'h2, {16'h0, ~lfsrQ[15:0]});
      bus(1'b0, 4'h3, {16'h0, lfsrQ[15:0]});
    end
    be <= 4'h1;
    bus(1'b1, 4'h3, 32'hffff);
    be <= 4'h3;
    bus(1'b0, 4'h3, {16'h0, lfsrQ[15:8], 8'hff});
    chk({24'h0, output_discrete_bus}, 32'hff);
    bus(1'b1, 4'h2, 32'h0);
    $display("test discrete done");
    test_mode_n <= 1'b0;
    repeat (6) @(posedge mclk);
    chk({31'h0, outputDiscreteOe}, 32'h0);
    test_mode_n <= 1'b1;
    repeat (6) @(posedge mclk);
    $display("test mode done");
    for (int k = 0; k < 6; k++) begin
      ioBusCycle <= (k == 1);
      memBusCycle <= (k == 2);
      cpuOwnsBus <= (k == 4);
      pulse(fSel[k]);
      repeat (5) @(posedge mclk);
      bus(1'b1, 4'h0, 32'hffff);
      bus(1'b0, 4'h0, 32'h1 << fBit[k]);
      chk({31'h0, faultRequest}, 32'h1);
      repeat (20) @(posedge mclk);
      bus(1'b1, 4'h0, 32'hffff);
      bus(1'b0, 4'h0, 32'h0);
      chk({31'h0, faultRequest}, 32'h0);
    end
    $display("test faults done");
    bus(1'b1, 4'h2, 32'h0055);
    for (int i = 0; i < 7; i++) begin
      irqN[i] <= 1'b0;
      repeat (3) @(posedge mclk);
      irqN[i] <= 1'b1;
      repeat (4) @(posedge mclk);
      bus(1'b0, 4'h1, (32'h2 << i) - 32'h1);
      chk({31'h0, userIrqRequest}, {31'h0, i > 0});
    end
    bus(1'b1, 4'h1, 32'hffff);
    bus(1'b1, 4'h2, 32'hffff);
    pulse(3'h4);
    repeat (6) @(posedge mclk);
    chk({31'h0, powerFailInterrupt}, 32'h1);
    bus(1'b0, 4'h1, 32'h8000);
    repeat (20) @(posedge mclk);
    bus(1'b1, 4'h1, 32'hffff);
    bus(1'b0, 4'h1, 32'h0);
    $display("test interrupts done");
    bus(1'b1, 4'h2, 32'h0);
    bus(1'b1, 4'h3, 32'h005a);
    irqN[1] <= 1'b0;
    repeat (3) @(posedge mclk);
    irqN[1] <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({31'h0, userIrqRequest}, 32'h1);
    test_mode_n <= 1'b0;
    master_reset_n <= 1'b0;
    repeat (6) @(posedge mclk);
    test_mode_n <= 1'b1;
    repeat (2) @(posedge mclk);
    master_reset_n <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({24'h0, output_discrete_bus}, 32'h0);
    bus(1'b0, 4'h1, 32'h0);
    bus(1'b0, 4'h3, 32'h0);
    $display("test master reset done");
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
